// File: pkg/tws_pkg.sv
// ==========================================================
// shared constants for the two-wire memory slave
package tws_pkg;
    // memory geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam int PAGE_BYTES = 8;
    localparam int SLOT_W = 3;

    // bit counting inside a byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] LAST_SLOT = 4'h7;

    // address byte layout
    localparam int DEV_RW_BIT = 0;
    localparam int DEV_SEL_BIT = 1;
    localparam int DEV_TYPE_LSB = 2;
    localparam int DEV_TYPE_MSB = 7;
    // device-type code: value is arbitrary
    localparam logic [5:0] DEV_TYPE_DEFAULT = 6'h2A;

    // pin synchroniser lanes and their reset levels
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_WP = 2;
    localparam int PIN_SEL = 3;
    localparam logic [3:0] SYNC_RST = 4'h7;

    // internal write cycle time
    localparam int SYS_CLK_NS = 20;
    localparam int WRITE_TIME_NS = 5000000;
    localparam int WR_CYCLES_DEFAULT = WRITE_TIME_NS / SYS_CLK_NS;

    typedef enum logic [3:0] {
        ST_IDLE, ST_DEV, ST_DEV_ACK, ST_ADDR, ST_ADDR_ACK,
        ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK, ST_COMMIT
    } tws_state_t;
endpackage

// File: rtl/tws_sync.sv
// ==========================================================
// three-stage pin synchroniser with agreement filter
module tws_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // meta feeds only stage2; a lane moves once stages agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta <= din;
            stage2 <= meta;
            stage3 <= stage2;
            dout <= (stage2 & stage3) | (dout & (stage2 ^ stage3));
        end
    end
endmodule

// File: rtl/tws_mem.sv
// ==========================================================
// byte memory, one write port and an unclocked read port
module tws_mem (
    input wire logic clk,
    input wire logic we,
    input wire logic [tws_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [tws_pkg::DATA_W-1:0] wrData,
    input wire logic [tws_pkg::ADDR_W-1:0] rdAddr,
    output logic [tws_pkg::DATA_W-1:0] rdData
);
    import tws_pkg::*;

    logic [DATA_W-1:0] store [MEM_DEPTH];

    // contents are kept across resets, as nonvolatile cells are
    always_ff @(posedge clk) begin
        if (we) begin
            store[wrAddr] <= wrData;
        end
    end

    // read is combinational so the first bit is ready at once
    assign rdData = store[rdAddr];
endmodule

// File: rtl/tws_slave.sv
// Contract
// - accept up to eight data bytes into one page per write transfer
// - page write address wraps inside the page, low bits only
// - buffered bytes commit only after stop, else they are discarded
// - no address acknowledge while the internal write cycle runs
// - address register holds last address used plus one
// - address register wraps from the top to location zero
// - current read sends byte at address register after address ack
// - master acknowledge makes device increment and send next byte
// - master no-acknowledge makes device release data line high
// - data line change while clock high is a control condition
// - start is data falling with clock high, then address byte
// - stop is data rising with clock high, ending the transfer
// - bytes move msb first, receiver holds ack low on ninth clock
// - works at both standard and fast clock rates
// - address byte is type code, select bit, then direction bit
// - direction one means read, zero means write
// - acknowledge address only on type code and select match
// - write-protect high blocks every memory change
// - write is address byte then data, timed write after stop
// - unmatched address returns to idle without driving data
// - data driven low only; sample on rise, change after fall
module tws_slave #(
    parameter int WR_CYCLES = tws_pkg::WR_CYCLES_DEFAULT,
    parameter logic [5:0] DEV_TYPE = tws_pkg::DEV_TYPE_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic linkClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic writeProtect,
    input wire logic device_select_pin,
    output logic sdaOut,
    output logic sdaOe,
    output logic writeBusy
);
    import tws_pkg::*;

    // ======================================================
    // link side: pin sampling and bus conditions
    tws_state_t state;
    logic [3:0] pinSync;
    logic sclF, sdaF, wpF, selF;
    logic prevScl, prevSda;
    logic sclRise, sclFall, startDet, stopDet, byteDone;
    logic [3:0] bitCnt;
    logic [DATA_W-1:0] shiftReg;
    logic [ADDR_W-1:0] addrReg;
    logic isRead, ackSeen, devMatch;
    logic [DATA_W-1:0] pageData [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pageValid;
    logic [ADDR_W-SLOT_W-1:0] pageBase;
    logic [DATA_W-1:0] rdData;
    logic memWe, commitEnd;
    logic busyLocal, reqTgl, doneTgl;
    logic doneMeta, doneSafe, donePrev;

    tws_sync #(.W(4), .RST_VAL(SYNC_RST)) uSync (
        .clk(linkClk),
        .rstn(rstn),
        .din({device_select_pin, writeProtect, sdaIn, sclIn}),
        .dout(pinSync)
    );

    assign sclF = pinSync[PIN_SCL];
    assign sdaF = pinSync[PIN_SDA];
    assign wpF = pinSync[PIN_WP];
    assign selF = pinSync[PIN_SEL];

    // previous filtered levels for edge detection
    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            prevScl <= 1'b1;
            prevSda <= 1'b1;
        end else begin
            prevScl <= sclF;
            prevSda <= sdaF;
        end
    end

    // data moving under a high clock is never data
    assign sclRise = sclF & ~prevScl;
    assign sclFall = ~sclF & prevScl;
    assign startDet = sclF & prevScl & prevSda & ~sdaF;
    assign stopDet = sclF & prevScl & ~prevSda & sdaF;
    assign byteDone = sclFall && (bitCnt == BITS_PER_BYTE);

    // type code, select pin, and no write cycle in flight
    assign devMatch =
        (shiftReg[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE) &&
        (shiftReg[DEV_SEL_BIT] == selF) &&
        !busyLocal;

    assign commitEnd = (state == ST_COMMIT) && (bitCnt == LAST_SLOT);

    // ======================================================
    // protocol engine
    // sampling on rise, driving after fall
    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            bitCnt <= '0;
            shiftReg <= '0;
            addrReg <= '0;
            isRead <= 1'b0;
            sdaOe <= 1'b0;
        end else if (state == ST_COMMIT) begin
            // bus is ignored until the page is in memory
            bitCnt <= 4'(bitCnt + 4'h1);
            if (commitEnd) begin
                state <= ST_IDLE;
                bitCnt <= '0;
            end
        end else if (startDet) begin
            // start or repeated start opens a new transfer
            state <= ST_DEV;
            bitCnt <= '0;
            sdaOe <= 1'b0;
        end else if (stopDet) begin
            // only a stop lets buffered bytes reach memory
            sdaOe <= 1'b0;
            bitCnt <= '0;
            state <= (|pageValid) ? ST_COMMIT : ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                end
                ST_DEV, ST_ADDR, ST_DATA: begin
                    if (sclRise) begin
                        // msb first
                        shiftReg <= {shiftReg[DATA_W-2:0], sdaF};
                        bitCnt <= 4'(bitCnt + 4'h1);
                    end else if (byteDone) begin
                        bitCnt <= '0;
                        if (state == ST_DEV) begin
                            if (devMatch) begin
                                sdaOe <= 1'b1;
                                isRead <= shiftReg[DEV_RW_BIT];
                                state <= ST_DEV_ACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else if (state == ST_ADDR) begin
                            addrReg <= shiftReg;
                            sdaOe <= 1'b1;
                            state <= ST_ADDR_ACK;
                        end else begin
                            // page wrap: high bits stay put
                            addrReg <= {addrReg[ADDR_W-1:SLOT_W],
                                SLOT_W'(addrReg[SLOT_W-1:0] + 3'h1)};
                            sdaOe <= 1'b1;
                            state <= ST_DATA_ACK;
                        end
                    end
                end
                ST_DEV_ACK, ST_ADDR_ACK, ST_DATA_ACK: begin
                    // ack held through the whole ninth clock
                    if (sclFall) begin
                        sdaOe <= 1'b0;
                        if (state == ST_DEV_ACK && isRead) begin
                            // current address byte goes out
                            shiftReg <= rdData;
                            sdaOe <= ~rdData[DATA_W-1];
                            state <= ST_TX;
                        end else if (state == ST_DEV_ACK) begin
                            state <= ST_ADDR;
                        end else begin
                            state <= ST_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (bitCnt == LAST_BIT) begin
                            sdaOe <= 1'b0;
                            bitCnt <= '0;
                            // full-width step wraps at the top
                            addrReg <= ADDR_W'(addrReg + 8'h01);
                            state <= ST_TX_ACK;
                        end else begin
                            shiftReg <= {shiftReg[DATA_W-2:0], 1'b0};
                            sdaOe <= ~shiftReg[DATA_W-2];
                            bitCnt <= 4'(bitCnt + 4'h1);
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (sclFall) begin
                        if (ackSeen) begin
                            shiftReg <= rdData;
                            sdaOe <= ~rdData[DATA_W-1];
                            state <= ST_TX;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_COMMIT: begin
                end
            endcase
        end
    end

    // master answer to a byte we sent, sampled on the rise
    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            ackSeen <= 1'b0;
        end else if (state == ST_TX_ACK && sclRise) begin
            ackSeen <= ~sdaF;
        end
    end

    // ======================================================
    // page buffer
    // a new start throws away whatever was not stopped
    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            pageValid <= '0;
            pageBase <= '0;
        end else if (startDet && state != ST_COMMIT) begin
            pageValid <= '0;
        end else if (commitEnd) begin
            pageValid <= '0;
        end else if (state == ST_DATA && byteDone) begin
            pageValid[addrReg[SLOT_W-1:0]] <= 1'b1;
            pageBase <= addrReg[ADDR_W-1:SLOT_W];
        end
    end

    // data lanes carry no reset; valid bits gate them
    always_ff @(posedge linkClk) begin
        if (state == ST_DATA && byteDone) begin
            pageData[addrReg[SLOT_W-1:0]] <= shiftReg;
        end
    end

    // protected device never writes a cell
    assign memWe = (state == ST_COMMIT) &&
        pageValid[bitCnt[SLOT_W-1:0]] && !wpF;

    tws_mem uMem (
        .clk(linkClk),
        .we(memWe),
        .wrAddr({pageBase, bitCnt[SLOT_W-1:0]}),
        .wrData(pageData[bitCnt[SLOT_W-1:0]]),
        .rdAddr(addrReg),
        .rdData(rdData)
    );

    // ======================================================
    // write cycle handshake, link side
    // busy is set locally at once so polling is refused at once
    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            busyLocal <= 1'b0;
            reqTgl <= 1'b0;
            doneMeta <= 1'b0;
            doneSafe <= 1'b0;
            donePrev <= 1'b0;
        end else begin
            doneMeta <= doneTgl;
            doneSafe <= doneMeta;
            donePrev <= doneSafe;
            if (commitEnd && !wpF) begin
                busyLocal <= 1'b1;
                reqTgl <= ~reqTgl;
            end else if (doneSafe != donePrev) begin
                busyLocal <= 1'b0;
            end
        end
    end

    // open drain: the output level is only ever low
    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end

    // ======================================================
    // write cycle timer, system side
    logic reqMeta, reqSafe, reqPrev;
    logic [31:0] timerCnt;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reqMeta <= 1'b0;
            reqSafe <= 1'b0;
            reqPrev <= 1'b0;
            writeBusy <= 1'b0;
            doneTgl <= 1'b0;
            timerCnt <= '0;
        end else begin
            reqMeta <= reqTgl;
            reqSafe <= reqMeta;
            reqPrev <= reqSafe;
            if (reqSafe != reqPrev) begin
                writeBusy <= 1'b1;
                timerCnt <= 32'(WR_CYCLES - 1);
            end else if (writeBusy) begin
                if (timerCnt == '0) begin
                    writeBusy <= 1'b0;
                    doneTgl <= ~doneTgl;
                end else begin
                    timerCnt <= 32'(timerCnt - 32'h1);
                end
            end
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge linkClk); endclocking
    default disable iff (!rstn);

    property p_nomatch_idle;
        state == ST_DEV && byteDone && !devMatch
            |=> state == ST_IDLE && !sdaOe;
    endproperty
    a_nomatch_idle: assert property (p_nomatch_idle)
        else $error("unmatched address not dropped");

    property p_busy_nack;
        busyLocal && state == ST_DEV && byteDone |=> !sdaOe;
    endproperty
    a_busy_nack: assert property (p_busy_nack)
        else $error("address acked during write cycle");

    property p_addr_ack;
        state == ST_ADDR && byteDone
            |=> sdaOe && state == ST_ADDR_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("memory address byte not acked");

    property p_page_wrap;
        state == ST_DATA && byteDone |=>
            addrReg[7:3] == $past(addrReg[7:3]) &&
            addrReg[2:0] == 3'($past(addrReg[2:0]) + 3'h1);
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("page address did not wrap in page");

    property p_start;
        startDet && state != ST_COMMIT
            |=> state == ST_DEV && bitCnt == 4'h0 && !sdaOe;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not open a transfer");

    property p_stop;
        stopDet && state != ST_COMMIT |=>
            (state == ST_IDLE || state == ST_COMMIT) && !sdaOe;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not end the transfer");

    property p_nack_release;
        state == ST_TX_ACK && sclFall && !ackSeen && !startDet
            && !stopDet |=> state == ST_IDLE && !sdaOe;
    endproperty
    a_nack_release: assert property (p_nack_release)
        else $error("data line held after master nack");

    property p_drive_after_fall;
        $rose(sdaOe) |-> $past(sclFall);
    endproperty
    a_drive_after_fall: assert property (p_drive_after_fall)
        else $error("data driven other than after a fall");

    property p_protect;
        memWe |-> !wpF && state == ST_COMMIT;
    endproperty
    a_protect: assert property (p_protect)
        else $error("memory written while protected");

    property p_seq_next;
        state == ST_TX && sclFall && bitCnt == LAST_BIT && !startDet
            && !stopDet |=> addrReg == 8'($past(addrReg) + 8'h01);
    endproperty
    a_seq_next: assert property (p_seq_next)
        else $error("address register did not advance");

    property p_timer;
        @(posedge sys_clk) disable iff (!rstn)
        reqSafe != reqPrev |=> writeBusy [*2];
    endproperty
    a_timer: assert property (p_timer)
        else $error("write cycle did not start");

    c_commit: cover property (commitEnd && !wpF);
    c_seq_read: cover property (state == ST_TX_ACK && sclFall && ackSeen);
    c_nomatch: cover property (state == ST_DEV && byteDone && !devMatch);
    c_busy_poll: cover property (busyLocal && state == ST_DEV && byteDone);
endmodule

// File: verification/tws_master_model.sv
// ==========================================================
// behavioural bus master; sda output 1 means line released
module tws_master_model (
    input wire logic linkClk,
    input wire logic sdaWire,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    int q = 52; // half period in link cycles, 624 ns
    logic lastBit;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge linkClk);
    endtask
    // one clock pulse; data only moves while scl is low
    task automatic bitIo(input logic b, output logic r);
        hold(1);
        sda <= b;
        hold(q);
        scl <= 1'b1;
        hold(q);
        r = sdaWire; // sampled at the end of the high time
        scl <= 1'b0;
        lastBit = r;
    endtask
    // from idle, or from scl low for a repeated start
    task automatic start();
        hold(1);
        sda <= 1'b1;
        hold(q);
        scl <= 1'b1;
        hold(q);
        sda <= 1'b0;
        hold(q);
        scl <= 1'b0;
    endtask
    task automatic stop();
        hold(1);
        sda <= 1'b0;
        hold(q);
        scl <= 1'b1;
        hold(q);
        sda <= 1'b1;
        hold(q);
    endtask
    task automatic writeByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitIo(b[i], r);
        bitIo(1'b1, r);
        ack = (r === 1'b0);
    endtask
    task automatic readByte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, r);
            d[i] = r;
        end
        bitIo(~more, r);
    endtask
endmodule

// File: verification/tws_slave_tb.sv
// ==========================================================
// self-checking bench for the two-wire memory slave
module tws_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tws_pkg::*;
    localparam int WR = 2000; // long enough to poll during it
    localparam int CEIL = 90000;
    logic sys_clk = 1'b0;
    logic linkClk = 1'b0;
    logic rstn = 1'b0;
    logic writeProtect = 1'b0;
    logic selPin = 1'b0;
    logic scl, mSda, sdaOut, sdaOe, writeBusy, sdaWire;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int busyRun = 0;
    int lastLen = 0;
    logic busySeen = 1'b0;
    logic [7:0] q [8];
    logic [7:0] d [8];

    // open-drain wire with pull-up
    assign sdaWire = mSda & ~sdaOe;
    always #10 sys_clk = ~sys_clk;
    initial begin
        #3;
        forever #6 linkClk = ~linkClk; // unrelated phase
    end

    tws_slave #(.WR_CYCLES(WR)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .linkClk(linkClk),
        .sclIn(scl), .sdaIn(sdaWire), .writeProtect(writeProtect),
        .device_select_pin(selPin), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .writeBusy(writeBusy));
    tws_master_model m (.linkClk(linkClk), .sdaWire(sdaWire),
        .scl(scl), .sda(mSda));

    // ==========================================================
    // busy length monitor and hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (writeBusy === 1'b1) begin
            busyRun <= busyRun + 1;
            busySeen <= 1'b1;
        end else begin
            if (busyRun != 0) lastLen <= busyRun;
            busyRun <= 0;
        end
        if (cyc == CEIL) begin
            bad_count++;
            $display("mismatch at %0t: timeout", $time);
            summarize();
        end
    end

    // ==========================================================
    // shared helpers
    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask
    function automatic logic [7:0] dev(input logic rw);
        return {DEV_TYPE_DEFAULT, selPin, rw};
    endfunction
    // write transfer from d; stop left out to cut it short
    task automatic wrSeq(input logic [7:0] a, input int n,
                         input bit doStop, output logic all);
        logic k;
        m.start();
        m.writeByte(dev(1'b0), all);
        m.writeByte(a, k);
        all &= k;
        for (int i = 0; i < n; i++) begin
            m.writeByte(d[i], k);
            all &= k;
        end
        if (doStop) m.stop();
    endtask
    // optional dummy write, then read n bytes into q
    task automatic rdSeq(input logic [7:0] a, input bit rnd, input int n);
        logic k;
        if (rnd) begin
            m.start();
            m.writeByte(dev(1'b0), k);
            m.writeByte(a, k);
        end
        m.start();
        m.writeByte(dev(1'b1), k);
        cmp(k, 1'b1, "read ack");
        for (int i = 0; i < n; i++) m.readByte(i < n - 1, q[i]);
        cmp(m.lastBit, 1'b1, "line released");
        m.stop();
    endtask
    task automatic waitWrite();
        int t = 0;
        while (writeBusy !== 1'b1 && t < 200) begin
            @(posedge sys_clk);
            t++;
        end
        cmp(t < 200, 1'b1, "busy started");
        t = 0;
        while (writeBusy === 1'b1 && t < WR + 400) begin
            @(posedge sys_clk);
            t++;
        end
        repeat (2) @(posedge sys_clk);
        cmp(lastLen >= WR && lastLen <= WR + 2, 1'b1, "cycle length");
        m.hold(20);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_page();
        logic k;
        for (int i = 0; i < 8; i++) d[i] = 8'hA0 + 8'(i);
        wrSeq(8'h35, 8, 1'b1, k);
        cmp(k, 1'b1, "page acks");
        cmp(sdaOut, 1'b0, "open drain level");
        for (int t = 0; t < 100 && writeBusy !== 1'b1; t++) @(posedge sys_clk);
        m.start();
        m.writeByte(dev(1'b0), k);
        m.stop();
        cmp(k, 1'b0, "poll while busy");
        waitWrite();
        rdSeq(8'h00, 1'b0, 1);
        cmp(q[0], 8'hA0, "address after page");
        rdSeq(8'h30, 1'b1, 6);
        for (int i = 0; i < 6; i++) cmp(q[i], 8'hA0 + 8'((i + 3) % 8), "slot");
        rdSeq(8'h00, 1'b0, 2);
        for (int i = 0; i < 2; i++) cmp(q[i], 8'hA1 + 8'(i), "sequence");
        $display("test page done");
    endtask
    task automatic t_wrap();
        logic k;
        d[0] = 8'h5A;
        wrSeq(8'h00, 1, 1'b1, k);
        waitWrite();
        d[0] = 8'hA5;
        wrSeq(8'hFF, 1, 1'b1, k);
        waitWrite();
        rdSeq(8'hFF, 1'b1, 2);
        cmp(q[0], 8'hA5, "top byte");
        cmp(q[1], 8'h5A, "wrap to zero");
        $display("test wrap done");
    endtask
    task automatic t_sel();
        logic k;
        logic [7:0] bad [2];
        bad[0] = {DEV_TYPE_DEFAULT ^ 6'h01, selPin, 1'b1};
        bad[1] = {DEV_TYPE_DEFAULT, ~selPin, 1'b1};
        for (int i = 0; i < 2; i++) begin
            m.start();
            m.writeByte(bad[i], k);
            m.stop();
            cmp(k, 1'b0, "foreign address");
        end
        @(posedge sys_clk) selPin <= 1'b1;
        m.hold(20);
        rdSeq(8'h00, 1'b1, 1);
        cmp(q[0], 8'h5A, "select pin high");
        @(posedge sys_clk) selPin <= 1'b0;
        m.hold(20);
        $display("test select done");
    endtask
    task automatic t_abort();
        logic k;
        d[0] = 8'h11;
        wrSeq(8'h40, 1, 1'b1, k);
        waitWrite();
        d[0] = 8'h22;
        busySeen = 1'b0;
        wrSeq(8'h40, 1, 1'b0, k);
        rdSeq(8'h40, 1'b1, 1);
        cmp(q[0], 8'h11, "unstopped data");
        cmp(busySeen, 1'b0, "no cycle");
        $display("test abort done");
    endtask
    task automatic t_wp();
        logic k;
        @(posedge sys_clk) writeProtect <= 1'b1;
        m.hold(20);
        busySeen = 1'b0;
        d[0] = 8'h33;
        wrSeq(8'h40, 1, 1'b1, k);
        cmp(k, 1'b1, "protected acks");
        m.hold(300);
        cmp(busySeen, 1'b0, "protected cycle");
        rdSeq(8'h40, 1'b1, 1);
        cmp(q[0], 8'h11, "protected byte");
        @(posedge sys_clk) writeProtect <= 1'b0;
        $display("test protect done");
    endtask
    task automatic t_slow();
        logic k;
        m.q = 400; // standard rate, 4.8 us half period
        d[0] = 8'hC3;
        wrSeq(8'h41, 1, 1'b1, k);
        cmp(k, 1'b1, "slow acks");
        waitWrite();
        rdSeq(8'h41, 1'b1, 1);
        cmp(q[0], 8'hC3, "slow readback");
        m.q = 52;
        $display("test slow done");
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        m.hold(20);
        t_page();
        t_wrap();
        t_sel();
        t_abort();
        t_wp();
        t_slow();
        summarize();
    end
endmodule
